// ### src/spw_top.sv
// pulse width detector with apb registers and interrupt
//
// Function
// R1: detection runs only while enable bit set
// R2: disabled, width registers are plain read/write
// R3: enabled, pin sampled and pulse widths measured
// R4: edge loads count, then counter restarts
// R5: high flag on long high or saturation
// R6: low flag on long low or saturation
// R7: pattern interrupts use vector one
// R8: firmware writes thresholds, then mask bits
// R9: mask blocks interrupt, flag still sets
// R10: masked, widths still load for polling
// R11: firmware clears flags before leaving handler
// R12: global enable set by enable, cleared by disable
// R13: three-bit debounce strength field
// R14: sample rate divides clock by two-power
// R15: control bits three and seven read zero
// R16: width registers zero, control 0x70 at reset
// R17: counter saturates; debounce needs persistent level
// R18: interrupt needs flag, mask and global enable
//
// Implementation choices: the APB register port and the placing of the registers.
module spw_top (
    // clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [spw_pkg::ADDR_W-1:0] paddr_i,
    input wire logic [spw_pkg::DATA_W-1:0] pwdata_i,
    output logic [spw_pkg::DATA_W-1:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // serial pattern pin
    input wire logic pattern_input_pin_i,
    // interrupt
    output logic irq_o,
    output logic [15:0] irq_vector_o
);
    import spw_pkg::*;

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
        return a == off;
    endfunction

    logic pready_q, pslverr_q;
    logic [DATA_W-1:0] prdata_q;
    logic [7:0] high_width_count_q, high_width_count_d;
    logic [7:0] low_width_count_q, low_width_count_d;
    logic [7:0] pattern_control_q;
    logic [7:0] system_control_q;
    logic [1:0] pat_flag_q, pat_mask_q, pat_ev;
    logic gie_q, irq_q;
    logic [15:0] vector_q;
    logic [DIV_W-1:0] div_q;
    logic [7:0] count_q, count_d;
    logic ovf_q, ovf_d;
    logic filt_level, filt_rise, filt_fall;

    // apb handshake: one wait state, write and read clear land on the last edge
    wire acc = psel_i & penable_i & ~pready_q;
    wire done = psel_i & penable_i & pready_q;
    wire wr = done & pwrite_i;
    wire rd_flag = done & ~pwrite_i & hit(paddr_i, OFF_FLAG);
    wire mapped = hit(paddr_i, OFF_HIGH) | hit(paddr_i, OFF_LOW) | hit(paddr_i, OFF_CTRL)
        | hit(paddr_i, OFF_SYS) | hit(paddr_i, OFF_FLAG) | hit(paddr_i, OFF_MASK)
        | hit(paddr_i, OFF_GIE);
    wire [7:0] rd_byte =
        hit(paddr_i, OFF_HIGH) ? high_width_count_q :
        hit(paddr_i, OFF_LOW) ? low_width_count_q :
        hit(paddr_i, OFF_CTRL) ? pattern_control_q :
        hit(paddr_i, OFF_SYS) ? system_control_q :
        hit(paddr_i, OFF_FLAG) ? {pat_flag_q, 6'h00} :
        hit(paddr_i, OFF_MASK) ? {pat_mask_q, 6'h00} :
        hit(paddr_i, OFF_GIE) ? {7'h00, gie_q} : 8'h00;

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= DATA_ZERO;
        end else begin
            pready_q <= acc;
            pslverr_q <= acc & ~mapped;
            if (acc) begin
                prdata_q <= pwrite_i ? DATA_ZERO : {24'h00_0000, rd_byte};
            end
        end
    end

    // control registers
    wire enable = system_control_q[SYS_EN_BIT];
    wire [FLD_W-1:0] debounce_field = pattern_control_q[DEBOUNCE_LSB +: FLD_W];
    wire [FLD_W-1:0] rate_field = pattern_control_q[RATE_LSB +: FLD_W];

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pattern_control_q <= CTRL_RESET; // R16
            system_control_q <= SYS_RESET;
            pat_mask_q <= PAIR_ZERO;
            gie_q <= 1'b0;
        end else if (wr) begin
            if (hit(paddr_i, OFF_CTRL)) begin
                pattern_control_q <= pwdata_i[7:0] & CTRL_WMASK; // R15
            end
            if (hit(paddr_i, OFF_SYS)) begin
                system_control_q <= pwdata_i[7:0]; // R1
            end
            if (hit(paddr_i, OFF_MASK)) begin
                pat_mask_q <= pwdata_i[PAT_LSB +: 2];
            end
            if (hit(paddr_i, OFF_GIE)) begin
                gie_q <= pwdata_i[GIE_BIT]; // R12
            end
        end
    end

    // sample prescaler: a tick every 2**rate clocks
    wire [DIV_W-1:0] rate_mask = DIV_W'((DIV_ONE << rate_field) - DIV_ONE);
    wire tick = enable & ((div_q & rate_mask) == rate_mask); // R14

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            div_q <= DIV_ZERO;
        end else begin
            div_q <= enable ? div_q + DIV_ONE : DIV_ZERO;
        end
    end

    spw_debounce u_debounce (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .pin_i(pattern_input_pin_i),
        .enable_i(enable),
        .tick_i(tick),
        .debounce_level_i(debounce_field),
        .level_o(filt_level),
        .rise_o(filt_rise),
        .fall_o(filt_fall)
    );

    // width counter; ovf remembers a pulse that outran the saturated count
    wire edge_seen = filt_rise | filt_fall;
    wire reach_max = tick & ~edge_seen & (count_q == CNT_MAX - CNT_ONE);

    always_comb begin
        count_d = count_q;
        ovf_d = ovf_q;
        if (!enable) begin
            count_d = 8'h00; // R1
            ovf_d = 1'b0;
        end else if (edge_seen) begin
            count_d = 8'h00; // R4
            ovf_d = 1'b0;
        end else if (tick) begin
            if (count_q == CNT_MAX) begin
                ovf_d = 1'b1; // R17
            end else begin
                count_d = count_q + CNT_ONE; // R3 R17
            end
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            count_q <= 8'h00;
            ovf_q <= 1'b0;
        end else begin
            count_q <= count_d;
            ovf_q <= ovf_d;
        end
    end

    // width registers: a hardware load beats a software write in the same cycle
    always_comb begin
        high_width_count_d = high_width_count_q;
        low_width_count_d = low_width_count_q;
        if (wr && hit(paddr_i, OFF_HIGH)) begin
            high_width_count_d = pwdata_i[7:0]; // R2
        end
        if (wr && hit(paddr_i, OFF_LOW)) begin
            low_width_count_d = pwdata_i[7:0]; // R2
        end
        if (enable && filt_fall) begin
            high_width_count_d = count_q; // R4 R10
        end
        if (enable && filt_rise) begin
            low_width_count_d = count_q; // R4 R10
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            high_width_count_q <= WIDTH_RESET; // R16
            low_width_count_q <= WIDTH_RESET; // R16
        end else begin
            high_width_count_q <= high_width_count_d;
            low_width_count_q <= low_width_count_d;
        end
    end

    // flag events; the threshold is the width register before it reloads
    assign pat_ev[SRC_HI] = enable & ((filt_fall & ((count_q > high_width_count_q) | ovf_q))
        | (reach_max & filt_level)); // R5
    assign pat_ev[SRC_LO] = enable & ((filt_rise & ((count_q > low_width_count_q) | ovf_q))
        | (reach_max & ~filt_level)); // R6

    // a read clears only what it returned, and a new event wins over the clear
    generate
        for (genvar i = 0; i < 2; i++) begin : g_flag
            always_ff @(posedge clk_i or negedge resetn_i) begin
                if (!resetn_i) begin
                    pat_flag_q[i] <= 1'b0;
                end else begin
                    pat_flag_q[i] <= pat_ev[i]
                        | (pat_flag_q[i] & ~(rd_flag & prdata_q[PAT_LSB + i])); // R9 R11
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            irq_q <= 1'b0;
            vector_q <= IRQ_VECTOR;
        end else begin
            irq_q <= gie_q & |(pat_flag_q & pat_mask_q); // R9 R18
            vector_q <= IRQ_VECTOR; // R7
        end
    end

    assign prdata_o = prdata_q;
    assign pready_o = pready_q;
    assign pslverr_o = pslverr_q;
    assign irq_o = irq_q;
    assign irq_vector_o = vector_q;

    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    // enable gating
    AST_IDLE_COUNT: assert property (!enable |=> count_q == 8'h00) // R1
        else $error("counter runs while disabled");
    AST_DIV_IDLE: assert property (!enable |=> div_q == DIV_ZERO) // R1
        else $error("prescaler runs while disabled");
    AST_IDLE_FLAGS: assert property (!enable // R1
        |=> (pat_flag_q & ~$past(pat_flag_q)) == PAIR_ZERO)
        else $error("flag set while disabled");
    AST_EDGE_ENABLED: assert property (edge_seen |-> $past(enable)) // R1
        else $error("edge accepted while disabled");

    // width registers and counter
    AST_GP_WRITE: assert property (!enable && wr && hit(paddr_i, OFF_HIGH) // R2
        |=> high_width_count_q == $past(pwdata_i[7:0]))
        else $error("high width register not writable while disabled");
    AST_GP_WRITE_LOW: assert property (!enable && wr && hit(paddr_i, OFF_LOW) // R2
        |=> low_width_count_q == $past(pwdata_i[7:0]))
        else $error("low width register not writable while disabled");
    AST_IDLE_HOLD: assert property (!enable && !wr // R2
        |=> high_width_count_q == $past(high_width_count_q)
        && low_width_count_q == $past(low_width_count_q))
        else $error("width register changed while idle");
    AST_COUNT_HOLD: assert property (enable && !tick && !edge_seen // R3
        |=> count_q == $past(count_q))
        else $error("counter moved without a sample tick");
    AST_COUNT_STEP: assert property (tick && !edge_seen && count_q != CNT_MAX // R17
        |=> count_q == $past(count_q) + CNT_ONE)
        else $error("counter did not advance on tick");
    AST_COUNT_SAT: assert property (tick && !edge_seen && count_q == CNT_MAX // R17
        |=> count_q == CNT_MAX && ovf_q)
        else $error("counter did not saturate");
    AST_LOAD_HIGH: assert property (enable && filt_fall // R4
        |=> high_width_count_q == $past(count_q) && count_q == 8'h00)
        else $error("falling edge did not load high width");
    AST_LOAD_LOW: assert property (enable && filt_rise // R4
        |=> low_width_count_q == $past(count_q) && count_q == 8'h00)
        else $error("rising edge did not load low width");
    AST_RESTART: assert property (enable && edge_seen |=> !ovf_q) // R4
        else $error("overflow not cleared at edge");

    // debounced edges
    AST_EDGE_EXCL: assert property (!(filt_rise && filt_fall)) // R4
        else $error("rise and fall together");
    AST_LEVEL_RISE: assert property (filt_rise |-> filt_level) // R4
        else $error("rise without high level");
    AST_LEVEL_FALL: assert property (filt_fall |-> !filt_level) // R4
        else $error("fall without low level");
    AST_EDGE_TICK: assert property (edge_seen |-> $past(tick)) // R13
        else $error("edge accepted off a sample tick");

    // pattern flags
    AST_HIGH_FLAG: assert property (enable && filt_fall && count_q > high_width_count_q // R5
        |=> pat_flag_q[SRC_HI])
        else $error("long high pulse did not set high flag");
    AST_HIGH_SAT: assert property (reach_max && enable && filt_level // R5
        |=> pat_flag_q[SRC_HI])
        else $error("high saturation did not set high flag");
    AST_HIGH_OVF: assert property (enable && filt_fall && ovf_q // R5
        |=> pat_flag_q[SRC_HI])
        else $error("overlong high pulse did not set high flag");
    AST_LOW_FLAG: assert property (enable && filt_rise && count_q > low_width_count_q // R6
        |=> pat_flag_q[SRC_LO])
        else $error("long low pulse did not set low flag");
    AST_LOW_SAT: assert property (reach_max && enable && !filt_level // R6
        |=> pat_flag_q[SRC_LO])
        else $error("low saturation did not set low flag");
    AST_LOW_OVF: assert property (enable && filt_rise && ovf_q // R6
        |=> pat_flag_q[SRC_LO])
        else $error("overlong low pulse did not set low flag");
    AST_MASK_FLAG: assert property (pat_mask_q == PAIR_ZERO && enable && filt_rise // R9
        && count_q > low_width_count_q |=> pat_flag_q[SRC_LO])
        else $error("masked source did not record its flag");
    AST_STICKY_HI: assert property (pat_flag_q[SRC_HI] && !rd_flag // R11
        |=> pat_flag_q[SRC_HI])
        else $error("high flag cleared without a read");
    AST_STICKY_LO: assert property (pat_flag_q[SRC_LO] && !rd_flag // R11
        |=> pat_flag_q[SRC_LO])
        else $error("low flag cleared without a read");

    // control and prescaler
    AST_GIE_ON: assert property (wr && hit(paddr_i, OFF_GIE) && pwdata_i[GIE_BIT] // R12
        |=> gie_q)
        else $error("global enable not set");
    AST_GIE_OFF: assert property (wr && hit(paddr_i, OFF_GIE) && !pwdata_i[GIE_BIT] // R12
        |=> !gie_q)
        else $error("global enable not cleared");
    AST_RATE_ZERO: assert property (enable && !(|rate_field) |-> tick) // R14
        else $error("undivided rate missed a tick");
    AST_RATE_GAP: assert property (tick && (|rate_field) // R14
        |=> !tick || !(|rate_field))
        else $error("divided rate ticked twice in a row");
    AST_CTRL_WRITE: assert property (wr && hit(paddr_i, OFF_CTRL) // R15
        |=> pattern_control_q == ($past(pwdata_i[7:0]) & CTRL_WMASK))
        else $error("control write not taken");
    AST_CTRL_RSV: assert property (!pattern_control_q[RSV_LO_BIT] // R15
        && !pattern_control_q[RSV_HI_BIT])
        else $error("reserved control bits set");

    // interrupt path
    AST_IRQ_RAISE: assert property (gie_q && (pat_flag_q & pat_mask_q) != PAIR_ZERO // R18
        |=> irq_o)
        else $error("interrupt not raised");
    AST_MASKED: assert property ((pat_flag_q & pat_mask_q) == PAIR_ZERO || !gie_q // R18
        |=> !irq_o)
        else $error("interrupt raised while masked");
    AST_VECTOR: assert property (irq_o |-> irq_vector_o == IRQ_VECTOR) // R7
        else $error("wrong interrupt vector");
endmodule

// ### src/spw_pkg.sv
// constants for the serial pulse width detector
package spw_pkg;
    // apb map
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] OFF_HIGH = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_LOW = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_SYS = 8'h0C;
    localparam logic [ADDR_W-1:0] OFF_FLAG = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_MASK = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_GIE = 8'h18;
    // reset values and writable bits
    localparam logic [7:0] WIDTH_RESET = 8'h00;
    localparam logic [7:0] CTRL_RESET = 8'h70;
    localparam logic [7:0] CTRL_WMASK = 8'h77;
    localparam logic [7:0] SYS_RESET = 8'h00;
    localparam logic [1:0] PAIR_ZERO = 2'h0;
    localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;
    // field positions
    localparam int SYS_EN_BIT = 2;
    localparam int DEBOUNCE_LSB = 0;
    localparam int RATE_LSB = 4;
    localparam int FLD_W = 3;
    localparam int RSV_LO_BIT = 3;
    localparam int RSV_HI_BIT = 7;
    localparam int PAT_LSB = 6;
    localparam int SRC_HI = 0;
    localparam int SRC_LO = 1;
    localparam int GIE_BIT = 0;
    // counting
    localparam int DIV_W = 7;
    localparam logic [7:0] CNT_MAX = 8'hFF;
    localparam logic [7:0] CNT_ONE = 8'h01;
    localparam logic [FLD_W-1:0] RUN_ZERO = 3'h0;
    localparam logic [FLD_W-1:0] RUN_ONE = 3'h1;
    localparam logic [DIV_W-1:0] DIV_ZERO = 7'h00;
    localparam logic [DIV_W-1:0] DIV_ONE = 7'h01;
    localparam logic [15:0] IRQ_VECTOR = 16'h0001;
endpackage

// ### src/spw_debounce.sv
// pin synchroniser and sample-based debounce filter
module spw_debounce (
    // clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // pin and control
    input wire logic pin_i,
    input wire logic enable_i,
    input wire logic tick_i,
    input wire logic [spw_pkg::FLD_W-1:0] debounce_level_i,
    // debounced result
    output logic level_o,
    output logic rise_o,
    output logic fall_o
);
    import spw_pkg::*;

    logic sync1_q, sync2_q;
    logic stable_q;
    logic [FLD_W-1:0] run_q;
    logic rise_q, fall_q;

    wire differs = sync2_q != stable_q;
    wire accept = enable_i & tick_i & differs & (run_q >= debounce_level_i);

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
        end else begin
            sync1_q <= pin_i;
            sync2_q <= sync1_q;
        end
    end

    // while idle the level tracks the pin so enabling makes no false edge
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            stable_q <= 1'b0;
            run_q <= RUN_ZERO;
        end else if (!enable_i) begin
            stable_q <= sync2_q;
            run_q <= RUN_ZERO;
        end else if (accept) begin
            stable_q <= sync2_q; // R13 R17
            run_q <= RUN_ZERO;
        end else if (tick_i) begin
            run_q <= differs ? run_q + RUN_ONE : RUN_ZERO; // R17
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rise_q <= 1'b0;
            fall_q <= 1'b0;
        end else begin
            rise_q <= accept & sync2_q;
            fall_q <= accept & ~sync2_q;
        end
    end

    assign level_o = stable_q;
    assign rise_o = rise_q;
    assign fall_o = fall_q;
endmodule

// ### tb/spw_pulse_src.sv
// pulse source standing in for the receiver output line
module spw_pulse_src (
    // clock
    input wire logic clk_i,
    // serial line, always driven
    output logic pin_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial pin_o = 1'b0;
    // level set just after an edge and held n clocks
    task automatic hold(input logic lvl, input int n);
        @(posedge clk_i);
        pin_o <= lvl;
        repeat (n - 1) @(posedge clk_i);
    endtask
endmodule

// ### tb/tb_serial_pulse_width_detector.sv
// self-checking bench for the pulse width detector
module tb_serial_pulse_width_detector;
    timeunit 1ns;
    timeprecision 1ps;
    import spw_pkg::*;
    logic clk_i, resetn_i, psel, penable, pwrite, pin, pready, pslverr, irq;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [15:0] vec;
    int n_mismatch = 0;
    int n_compared = 0;

    spw_top dut (.clk_i(clk_i), .resetn_i(resetn_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .pattern_input_pin_i(pin),
        .irq_o(irq), .irq_vector_o(vec));
    spw_pulse_src src (.clk_i(clk_i), .pin_o(pin));

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    // answer taken only at the edge where pready is seen high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] r, output logic e);
        int n;
        n = 0;
        @(posedge clk_i);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_i);
        penable <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
        end while (pready !== 1'b1 && n < 20);
        r = prdata;
        e = pslverr;
        if (n >= 20) cmp(pready, 1'b1, "apb stall");
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, {24'h00_0000, d}, r, e);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] x);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, DATA_ZERO, r, e);
        cmp(r, x, "read");
    endtask

    task automatic rdr(input logic [7:0] a, input int lo, input int hi);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, DATA_ZERO, r, e);
        n_compared++;
        if ((r >= lo && r <= hi) !== 1'b1) begin
            n_mismatch++;
            $display("wrong value at %0t: width %h", $time, r);
        end
    endtask

    task automatic wait_irq(input logic lvl);
        int n;
        n = 0;
        while (irq !== lvl && n < 20) begin
            @(posedge clk_i);
            n++;
        end
        cmp(irq, lvl, "irq");
    endtask

    task automatic t_regs();
        logic [31:0] r;
        logic e;
        rd(OFF_HIGH, 8'h00);
        rd(OFF_LOW, 8'h00);
        rd(OFF_CTRL, 8'h70);
        apb(1'b0, 8'h1C, DATA_ZERO, r, e);
        cmp(e, 1'b1, "unmapped");
        wr(OFF_CTRL, 8'hFF);
        rd(OFF_CTRL, 8'h77);
        wr(OFF_HIGH, 8'hA5);
        src.hold(1'b1, 20);
        src.hold(1'b0, 20);
        rd(OFF_HIGH, 8'hA5);
        rd(OFF_FLAG, 8'h00);
        $display("test regs done");
    endtask

    task automatic t_measure();
        wr(OFF_SYS, 8'h04);
        wr(OFF_CTRL, 8'h00);
        wr(OFF_HIGH, 8'h0A);
        wr(OFF_LOW, 8'hC8);
        src.hold(1'b1, 30);
        src.hold(1'b0, 8);
        rdr(OFF_HIGH, 29, 31);
        rdr(OFF_LOW, 1, 100);
        rd(OFF_FLAG, 8'h40);
        rd(OFF_FLAG, 8'h00);
        cmp(irq, 1'b0, "masked");
        wr(OFF_SYS, 8'h00);
        $display("test measure done");
    endtask

    task automatic t_irq();
        wr(OFF_SYS, 8'h04);
        wr(OFF_LOW, 8'h14);
        wr(OFF_MASK, 8'hC0);
        wr(OFF_GIE, 8'h01);
        src.hold(1'b0, 40);
        src.hold(1'b1, 6);
        wait_irq(1'b1);
        cmp(vec, 16'h0001, "vector");
        wr(OFF_GIE, 8'h00);
        wait_irq(1'b0);
        wr(OFF_GIE, 8'h01);
        wait_irq(1'b1);
        rd(OFF_FLAG, 8'h80);
        wait_irq(1'b0);
        wr(OFF_SYS, 8'h00);
        $display("test irq done");
    endtask

    task automatic t_sat();
        wr(OFF_SYS, 8'h04);
        wr(OFF_HIGH, 8'hFF);
        src.hold(1'b0, 300);
        rd(OFF_FLAG, 8'h80);
        src.hold(1'b1, 8);
        rd(OFF_LOW, 8'hFF);
        rd(OFF_FLAG, 8'h80);
        wr(OFF_SYS, 8'h00);
        $display("test saturate done");
    endtask

    task automatic t_rate();
        logic [31:0] r;
        logic e;
        wr(OFF_CTRL, 8'h20);
        wr(OFF_SYS, 8'h04);
        src.hold(1'b0, 40);
        src.hold(1'b1, 80);
        src.hold(1'b0, 24);
        rdr(OFF_HIGH, 19, 21);
        wr(OFF_CTRL, 8'h03);
        apb(1'b0, OFF_LOW, DATA_ZERO, r, e);
        // short glitch must not pass a strength-three filter
        src.hold(1'b1, 2);
        src.hold(1'b0, 12);
        rd(OFF_LOW, r[7:0]);
        src.hold(1'b1, 16);
        src.hold(1'b0, 16);
        rdr(OFF_HIGH, 15, 17);
        wr(OFF_SYS, 8'h00);
        $display("test rate done");
    endtask

    task automatic summarize();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    initial begin
        #100000;
        n_mismatch++;
        summarize();
    end

    initial begin
        resetn_i = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = DATA_ZERO;
        repeat (4) @(posedge clk_i);
        resetn_i <= 1'b1;
        t_regs();
        t_measure();
        t_irq();
        t_sat();
        t_rate();
        summarize();
    end
endmodule
